//--- include/acrt_pkg.sv
// Package for the conversion and result readout sequencer.
// Assumes a 125 MHz system clock; the times the core uses are turned into cycles here.
package acrt_pkg;

  localparam int RES_W      = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_NS     = 8;
  localparam int SINCE_W    = 10;
  localparam int CNT_W      = 8;

  // Internal conversion length, chosen to meet the data and frame delays.
  localparam int CONV_NS  = 1280;
  localparam int CONV_CYC = CONV_NS / CLK_NS;

  // Limits for the busy pulse and result delivery.
  localparam int BUSY_MAX_NS   = 1450;
  localparam int BUSY_MAX_CYC  = BUSY_MAX_NS / CLK_NS;
  localparam int DATA_MAX_NS   = 1410;
  localparam int DATA_MAX_CYC  = DATA_MAX_NS / CLK_NS;
  localparam int DATA_LEAD_NS  = 20;
  localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIPE_CYC      = 2;
  localparam int HOLD_CYC      = PIPE_CYC + DATA_LEAD_CYC;

  // Frame marker placement and busy release.
  localparam int RDC_SYNC_NS   = 560;
  localparam int RDC_SYNC_CYC  = RDC_SYNC_NS / CLK_NS;
  localparam int RAC_SYNC_NS   = 1310;
  localparam int RAC_SYNC_CYC  = RAC_SYNC_NS / CLK_NS;
  localparam int REL_NS        = 25;
  localparam int REL_CYC       = (REL_NS + CLK_NS - 1) / CLK_NS;

  // Serial clock figures per divider setting 0 to 3.
  localparam int SCK_HI_NS [4] = '{15, 30, 60, 120};
  localparam int SCK_LO_NS [4] = '{10, 25, 55, 115};
  localparam int SCK_PER_NS[4] = '{30, 60, 120, 240};
  localparam int LEAD_NS   [4] = '{3, 20, 20, 20};
  localparam int TAIL_NS   [4] = '{5, 7, 35, 90};
  localparam int RAC_BUSY_NS[4] = '{2250, 3000, 4400, 7300};

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_CONV = 3'b001,
    C_PUSH = 3'b010,
    C_HOLD = 3'b011,
    C_SER  = 3'b100,
    C_REL  = 3'b101
  } acrt_conv_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LEAD = 3'b001,
    S_HIGH = 3'b010,
    S_LOW  = 3'b011,
    S_TAIL = 3'b100
  } acrt_ser_t;

  function automatic int ceil_cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // Half period: covers both phase minima and half the period minimum.
  function automatic logic [5:0] half_cyc(input logic [1:0] div);
    int h;
    h = ceil_cyc(SCK_HI_NS[div]);
    if (ceil_cyc(SCK_LO_NS[div]) > h) h = ceil_cyc(SCK_LO_NS[div]);
    if (ceil_cyc(SCK_PER_NS[div] / 2) > h) h = ceil_cyc(SCK_PER_NS[div] / 2);
    return 6'(h);
  endfunction

  function automatic logic [5:0] lead_cyc(input logic [1:0] div);
    return 6'(ceil_cyc(LEAD_NS[div]));
  endfunction

  function automatic logic [5:0] tail_cyc(input logic [1:0] div);
    return 6'(ceil_cyc(TAIL_NS[div]));
  endfunction

endpackage

//--- hw/acrt_fifo.sv
// Result FIFO between the converter core and the readout ports.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/10ps
module acrt_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_flush,
  // Fill side.
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side.
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (i_flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      case ({push, pop})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end

endmodule // acrt_fifo

//--- hw/acrt_core.sv
// Conversion sequencing and result readout of a 16-bit SAR converter.
// Assumes synchronous inputs on i_mclk and an analog core that offers
// its settled result on i_sar_result at the end of the conversion time.
//
// Overview of operation
// - Busy high at most 1.45 us normally.
// - Each result readable once conversion completes.
// - Parallel data valid within 1.41 us.
// - Parallel data valid 20 ns before busy falls.
// - Read-during-convert frame starts 560 ns after start.
// - Read-after-convert frame starts 1.31 us after start.
// - Read-after-convert busy falls 25 ns after frame.
// - Serial clock period follows divider setting in read-after-convert; read during convert uses setting 0.
// - Serial clock keeps minimum high, low phases.
// - Read-after-convert busy bounded per divider setting.
// - Frame leads first clock edge by minimum.
// - Frame outlasts last clock edge by minimum.
// - Serial pins driven only while selected.
`timescale 1ns/10ps
module acrt_core (
  // Clock and reset.
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  // Conversion control.
  input  wire logic                       i_convert_start_n,
  input  wire logic                       i_conv_reset,
  input  wire logic                       i_cs_n,
  // Mode selection.
  input  wire logic                       i_interface_select,
  input  wire logic                       i_read_during_conv,
  input  wire logic [1:0]                 i_clock_divider_select,
  // Analog core result.
  input  wire logic [acrt_pkg::RES_W-1:0] i_sar_result,
  // Status.
  output logic                            o_busy,
  // Parallel result port.
  output logic [acrt_pkg::RES_W-1:0]      o_data,
  output logic                            o_data_oe,
  // Master serial port.
  output logic                            o_frame,
  output logic                            o_serial_shift_clock,
  output logic                            o_serial_result_out,
  output logic                            o_serial_oe
);
  import acrt_pkg::*;

  acrt_conv_t         conv_st_r;
  acrt_ser_t          ser_st_r;
  logic               cnv_prev_r, go, busy_r, done_r;
  logic               mode_ser_r, mode_rdc_r, arm_r, launch, pop_par;
  logic               fifo_iv, fifo_ir, fifo_ov, fifo_or;
  logic               frame_r, sclk_r, sdo_r, data_oe_r, ser_oe_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [SINCE_W-1:0] since_r;
  logic [SINCE_W-1:0] frame_at;
  logic [1:0]         div_r;
  logic [1:0]         div_eff;
  logic [RES_W-1:0]   fifo_dout;
  logic [RES_W-1:0]   data_r;
  logic [RES_W-1:0]   shift_r;
  logic [5:0]         ser_cnt_r;
  logic [4:0]         bit_cnt_r;

  // A falling edge on the start input starts a conversion when idle.
  // ignore early starts
  assign go = cnv_prev_r & ~i_convert_start_n & (conv_st_r == C_IDLE);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnv_prev_r <= 1'b1;
    end else begin
      cnv_prev_r <= i_convert_start_n;
    end
  end
  // Mode is latched at conversion start so mid-conversion changes reach only the output enables.
  // latch interface choice
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ser_r <= 1'b0;
      mode_rdc_r <= 1'b0;
      div_r      <= 2'h0;
    end else if (go) begin
      mode_ser_r <= i_interface_select;
      mode_rdc_r <= i_read_during_conv;
      div_r      <= i_clock_divider_select;
    end
  end
  // Read during convert always runs at the fastest serial clock.
  // divider selection
  assign div_eff = mode_rdc_r ? 2'h0 : div_r;
  // Time since the last start, saturating.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_r <= '0;
    end else if (go) begin
      since_r <= '0;
    end else if (since_r != '1) begin
      since_r <= since_r + 1'b1;
    end
  end
  // Conversion sequencer and busy output.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_st_r <= C_IDLE;
      cnt_r     <= '0;
      busy_r    <= 1'b0;
    end else if (i_conv_reset) begin
      conv_st_r <= C_IDLE;
      cnt_r     <= '0;
      busy_r    <= 1'b0;
    end else begin
      case (conv_st_r)
        C_IDLE: begin
          if (go) begin
            busy_r    <= 1'b1;
            cnt_r     <= '0;
            conv_st_r <= C_CONV;
          end
        end
        C_CONV: begin
          if (cnt_r == CNT_W'(CONV_CYC - 1)) begin
            conv_st_r <= C_PUSH;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        C_PUSH: begin
          if (fifo_ir) begin
            cnt_r     <= '0;
            conv_st_r <= (mode_ser_r & ~mode_rdc_r) ? C_SER : C_HOLD;
          end
        end
        C_HOLD: begin
          if (cnt_r == CNT_W'(HOLD_CYC - 1)) begin
            busy_r    <= 1'b0;
            conv_st_r <= C_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        C_SER: begin
          if (done_r) begin
            cnt_r     <= '0;
            conv_st_r <= C_REL;
          end
        end
        C_REL: begin
          if (cnt_r == CNT_W'(REL_CYC - 1)) begin
            busy_r    <= 1'b0;
            conv_st_r <= C_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          conv_st_r <= C_IDLE;
          busy_r    <= 1'b0;
        end
      endcase
    end
  end

  assign fifo_iv = (conv_st_r == C_PUSH);
  acrt_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_flush     (i_conv_reset),
    .i_in_valid  (fifo_iv),
    .o_in_ready  (fifo_ir),
    .i_in_data   (i_sar_result),
    .o_out_valid (fifo_ov),
    .i_out_ready (fifo_or),
    .o_out_data  (fifo_dout)
  );
  assign frame_at = mode_rdc_r ? SINCE_W'(RDC_SYNC_CYC) : SINCE_W'(RAC_SYNC_CYC);
  assign pop_par  = fifo_ov & ~mode_ser_r;
  assign launch   = arm_r & (since_r >= frame_at) & fifo_ov & (ser_st_r == S_IDLE);
  assign fifo_or  = pop_par | launch;
  // Serial frame is armed per conversion; read during convert drops it
  // when no earlier result is waiting.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arm_r <= 1'b0;
    end else if (i_conv_reset) begin
      arm_r <= 1'b0;
    end else if (go) begin
      arm_r <= i_interface_select;
    end else if (launch) begin
      arm_r <= 1'b0;
    end else if (mode_rdc_r & (since_r >= frame_at) & ~fifo_ov) begin
      arm_r <= 1'b0;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_r <= '0;
    end else if (pop_par) begin
      data_r <= fifo_dout;
    end
  end

  // Serial shifter, MSB first; data changes on falling clock edges.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser_st_r  <= S_IDLE;
      ser_cnt_r <= '0;
      bit_cnt_r <= '0;
      shift_r   <= '0;
      frame_r   <= 1'b0;
      sclk_r    <= 1'b0;
      sdo_r     <= 1'b0;
      done_r    <= 1'b0;
    end else if (i_conv_reset) begin
      ser_st_r <= S_IDLE;
      frame_r  <= 1'b0;
      sclk_r   <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (ser_st_r)
        S_IDLE: begin
          if (launch) begin
            shift_r   <= fifo_dout;
            sdo_r     <= fifo_dout[RES_W-1];
            frame_r   <= 1'b1;
            bit_cnt_r <= '0;
            ser_cnt_r <= lead_cyc(div_eff) - 1'b1;
            ser_st_r  <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (ser_cnt_r == '0) begin
            sclk_r    <= 1'b1;
            ser_cnt_r <= half_cyc(div_eff) - 1'b1;
            ser_st_r  <= S_HIGH;
          end else begin
            ser_cnt_r <= ser_cnt_r - 1'b1;
          end
        end
        S_HIGH: begin
          if (ser_cnt_r == '0) begin
            sclk_r    <= 1'b0;
            shift_r   <= {shift_r[RES_W-2:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == 5'(RES_W - 1)) begin
              ser_cnt_r <= tail_cyc(div_eff) - 1'b1;
              ser_st_r  <= S_TAIL;
            end else begin
              sdo_r     <= shift_r[RES_W-2];
              ser_cnt_r <= half_cyc(div_eff) - 1'b1;
              ser_st_r  <= S_LOW;
            end
          end else begin
            ser_cnt_r <= ser_cnt_r - 1'b1;
          end
        end
        S_LOW: begin
          if (ser_cnt_r == '0) begin
            sclk_r    <= 1'b1;
            ser_cnt_r <= half_cyc(div_eff) - 1'b1;
            ser_st_r  <= S_HIGH;
          end else begin
            ser_cnt_r <= ser_cnt_r - 1'b1;
          end
        end
        S_TAIL: begin
          if (ser_cnt_r == '0) begin
            frame_r  <= 1'b0;
            done_r   <= 1'b1;
            ser_st_r <= S_IDLE;
          end else begin
            ser_cnt_r <= ser_cnt_r - 1'b1;
          end
        end
        default: begin
          ser_st_r <= S_IDLE;
          frame_r  <= 1'b0;
          sclk_r   <= 1'b0;
        end
      endcase
    end
  end
  // Output enables follow device select within one cycle.
  // select gated drive
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_oe_r <= 1'b0;
      ser_oe_r  <= 1'b0;
    end else begin
      data_oe_r <= ~i_interface_select & ~i_cs_n;
      ser_oe_r  <= i_interface_select & ~i_cs_n;
    end
  end

  assign o_busy               = busy_r;
  assign o_data               = data_r;
  assign o_data_oe            = data_oe_r;
  assign o_frame              = frame_r;
  assign o_serial_shift_clock = sclk_r;
  assign o_serial_result_out  = sdo_r;
  assign o_serial_oe          = ser_oe_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n || i_conv_reset);

  a_busy_normal_max: assert property (
    $rose(o_busy) && !i_interface_select |-> ##[1:181] !o_busy)
    else $error("busy held too long");
  a_result_no_lag: assert property (
    fifo_iv && fifo_ir && !mode_ser_r |-> ##1 pop_par)
    else $error("result not handed on at once");
  a_par_data_time: assert property (
    go && !i_interface_select |-> ##[1:176] pop_par)
    else $error("parallel data late");
  a_data_lead_busy: assert property (
    $fell(o_busy) && !mode_ser_r |->
      !$past(pop_par, 1) && !$past(pop_par, 2) && !$past(pop_par, 3))
    else $error("data not settled before busy fell");
  a_rdc_frame_time: assert property (
    $rose(o_frame) && mode_rdc_r |-> since_r == SINCE_W'(RDC_SYNC_CYC + 1))
    else $error("read-during frame misplaced");
  a_rac_frame_time: assert property (
    $rose(o_frame) && !mode_rdc_r |-> since_r > SINCE_W'(RAC_SYNC_CYC))
    else $error("read-after frame too early");
  a_rac_busy_rel: assert property (
    $fell(o_frame) && mode_ser_r && !mode_rdc_r |-> o_busy[*5] ##1 !o_busy)
    else $error("busy release after frame wrong");
  a_sclk_high_min: assert property (
    $rose(o_serial_shift_clock) |-> o_serial_shift_clock[*2])
    else $error("serial clock high phase short");
  a_sclk_low_min: assert property (
    $fell(o_serial_shift_clock) && o_frame |-> !o_serial_shift_clock[*2])
    else $error("serial clock low phase short");
  a_rac_busy_max: assert property (
    $rose(o_busy) && i_interface_select && !i_read_during_conv
      |-> ##[1:912] !o_busy)
    else $error("read-after busy too long");
  a_frame_lead: assert property (
    $rose(o_frame) |-> !o_serial_shift_clock)
    else $error("clock edge with frame start");
  a_float_on_desel: assert property (
    i_cs_n |=> !o_serial_oe && !o_data_oe)
    else $error("pins driven while deselected");
  c_par_conv: cover property ($fell(o_busy) && !mode_ser_r);
  c_rdc_frame: cover property ($fell(o_frame) && mode_rdc_r);
  c_rac_slow: cover property ($fell(o_frame) && !mode_rdc_r && div_r == 2'h3);
  c_fifo_full: cover property (!fifo_ir);

endmodule // acrt_core

//--- dv/acrt_host_model.sv
// Host-side partner of the sequencer: pulses convert start, shifts in serial words.
// Assumes the bench raises i_go to ask for a start and lowers it once the pulse shows.
`timescale 1ns/10ps
module acrt_host_model (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Bench control.
  input  wire logic        i_go,
  input  wire logic        i_ignore_busy,
  // Device side.
  input  wire logic        i_busy,
  input  wire logic        i_frame,
  input  wire logic        i_sclk,
  input  wire logic        i_sdo,
  input  wire logic        i_soe,
  output logic             o_convert_start_n,
  output logic [15:0]      o_word
);
  logic [1:0] low_cnt_r;

  // start when idle.
  // The low phase lasts two cycles so the pulse is never too narrow.
  always @(negedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_convert_start_n <= 1'b1;
      low_cnt_r         <= 2'h0;
    end else if (low_cnt_r != 2'h0) begin
      low_cnt_r <= low_cnt_r - 2'h1;
      if (low_cnt_r == 2'h1) begin
        o_convert_start_n <= 1'b1;
      end
    end else if (i_go && (!i_busy || i_ignore_busy)) begin
      o_convert_start_n <= 1'b0;
      low_cnt_r         <= 2'h2;
    end
  end

  // Bits are taken on the rising serial clock while framed and driven, MSB first.
  always @(posedge i_sclk) begin
    if (i_frame && i_soe) begin
      o_word <= {o_word[14:0], i_sdo};
    end
  end
endmodule // acrt_host_model

//--- dv/tb.sv
// Self-checking bench for the conversion and readout sequencer.
// Assumes the host model drives convert start and collects serial words.
`timescale 1ns/10ps
module tb;
  import acrt_pkg::*;
  localparam int LIMIT = 20000;
  localparam int BIG   = 99999;
  logic        i_mclk, i_rst_n, i_conv_reset, i_cs_n;
  logic        i_interface_select, i_read_during_conv, go, ign, psclk;
  logic [1:0]  i_clock_divider_select;
  logic [15:0] i_sar_result;
  wire  logic  i_convert_start_n, o_busy, o_data_oe, o_frame;
  wire  logic  o_serial_shift_clock, o_serial_result_out, o_serial_oe;
  wire  logic [15:0] o_data, o_word;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int busy_len, bfall, dchg, frise, ffall, srise1, sfall, nrise;
  int minhi, minlo, maxper, lastr, hi, lo, fbad;

  acrt_core i_acrt_core (.i_mclk, .i_rst_n, .i_convert_start_n, .i_conv_reset, .i_cs_n,
    .i_interface_select, .i_read_during_conv, .i_clock_divider_select, .i_sar_result,
    .o_busy, .o_data, .o_data_oe, .o_frame, .o_serial_shift_clock,
    .o_serial_result_out, .o_serial_oe);

  acrt_host_model i_acrt_host_model (.i_mclk, .i_rst_n, .i_go(go), .i_ignore_busy(ign),
    .i_busy(o_busy), .i_frame(o_frame), .i_sclk(o_serial_shift_clock),
    .i_sdo(o_serial_result_out), .i_soe(o_serial_oe), .o_convert_start_n(i_convert_start_n),
    .o_word(o_word));

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo_v, input int hi_v, input int got);
    samples_checked++;
    if (got < lo_v || got > hi_v) begin
      fail_count++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo_v, hi_v, got);
    end
  endtask

  task automatic flush();
    @(negedge i_mclk);
    i_conv_reset = 1'b1;
    @(negedge i_mclk);
    i_conv_reset = 1'b0;
  endtask

  // Runs one conversion and records, per cycle after the start, what the pins did.
  task automatic conv(input logic [15:0] v, input bit poke);
    i_sar_result = v;
    go = 1'b1;
    do begin
      @(negedge i_mclk);
      #1;
    end while (i_convert_start_n !== 1'b0);
    go = 1'b0;
    busy_len = 0;
    bfall = -1;
    dchg = -1;
    frise = -1;
    ffall = -1;
    srise1 = -1;
    sfall = -1;
    nrise = 0;
    minhi = BIG;
    minlo = BIG;
    maxper = 0;
    lastr = -1;
    hi = 0;
    lo = 0;
    fbad = 0;
    psclk = 1'b0;
    for (int k = 1; k < 1200 && !(bfall > 0 && k > bfall + 2); k++) begin
      @(negedge i_mclk);
      #1;
      if (poke) go = (k >= 40 && k < 43);
      if (o_busy === 1'b1) busy_len++;
      else if (bfall < 0) bfall = k;
      if (dchg < 0 && o_data === v) dchg = k;
      if (o_frame === 1'b1 && o_busy !== 1'b1) fbad++;
      if (o_frame === 1'b1 && frise < 0) frise = k;
      if (o_frame === 1'b0 && frise > 0 && ffall < 0) ffall = k;
      if (o_serial_shift_clock === 1'b1 && psclk === 1'b0) begin
        nrise++;
        if (srise1 < 0) srise1 = k;
        if (nrise > 1 && lo < minlo) minlo = lo;
        if (lastr > 0 && k - lastr > maxper) maxper = k - lastr;
        lastr = k;
        hi = 0;
      end
      if (o_serial_shift_clock === 1'b0 && psclk === 1'b1) begin
        sfall = k;
        if (hi < minhi) minhi = hi;
        lo = 0;
      end
      if (o_serial_shift_clock === 1'b1) hi++;
      else lo++;
      psclk = o_serial_shift_clock;
    end
  endtask

  task automatic t_select();
    i_interface_select = 1'b1;
    i_cs_n = 1'b1;
    @(negedge i_mclk);
    chk_val("serial oe deselected", 16'h0, 16'(o_serial_oe));
    chk_val("data oe in serial", 16'h0, 16'(o_data_oe));
    i_cs_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk_val("serial oe selected", 16'h1, 16'(o_serial_oe));
    i_interface_select = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk_val("data oe parallel", 16'h1, 16'(o_data_oe));
    chk_val("serial oe parallel", 16'h0, 16'(o_serial_oe));
  endtask

  task automatic chk_par(input logic [15:0] v);
    chk_rng("busy ns", 1, BUSY_MAX_NS, busy_len * CLK_NS);
    chk_rng("data ns", 0, DATA_MAX_NS, (dchg - 1) * CLK_NS);
    chk_rng("data lead ns", DATA_LEAD_NS, BIG, (bfall - dchg) * CLK_NS);
    chk_val("parallel data", v, o_data);
  endtask

  task automatic t_parallel();
    conv(16'hA5C3, 1'b0);
    chk_par(16'hA5C3);
    conv(16'h3C5A, 1'b0);
    chk_par(16'h3C5A);
    ign = 1'b1;
    conv(16'h5AA5, 1'b1);
    ign = 1'b0;
    chk_par(16'h5AA5);
  endtask

  task automatic t_rac();
    i_interface_select = 1'b1;
    i_read_during_conv = 1'b0;
    flush();
    for (int d = 0; d < 4; d++) begin
      i_clock_divider_select = 2'(d);
      conv(16'h9C31 ^ 16'(d), 1'b0);
      chk_val("rac word", 16'h9C31 ^ 16'(d), o_word);
      chk_rng("rac frame ns", RAC_SYNC_NS - CLK_NS, RAC_SYNC_NS + CLK_NS,
        (frise - 1) * CLK_NS);
      chk_rng("rac bits", 16, 16, nrise);
      chk_rng("rac period ns", SCK_PER_NS[d], SCK_PER_NS[d] * 3 / 2, maxper * CLK_NS);
      chk_rng("rac high ns", SCK_HI_NS[d], BIG, minhi * CLK_NS);
      chk_rng("rac low ns", SCK_LO_NS[d], BIG, minlo * CLK_NS);
      chk_rng("rac lead ns", LEAD_NS[d], BIG, (srise1 - frise) * CLK_NS);
      chk_rng("rac tail ns", TAIL_NS[d], BIG, (ffall - sfall) * CLK_NS);
      chk_rng("rac busy ns", 1, RAC_BUSY_NS[d], busy_len * CLK_NS);
      chk_rng("busy release ns", REL_NS, REL_NS + 2 * CLK_NS, (bfall - ffall) * CLK_NS);
      chk_rng("busy low in frame", 0, 0, fbad);
    end
  endtask

  task automatic t_rdc();
    i_read_during_conv = 1'b1;
    flush();
    conv(16'h1234, 1'b0);
    chk_rng("rdc frame when empty", -1, -1, frise);
    conv(16'hFEDC, 1'b0);
    chk_rng("rdc frame ns", RDC_SYNC_NS - CLK_NS, RDC_SYNC_NS + CLK_NS,
      (frise - 1) * CLK_NS);
    chk_val("rdc word", 16'h1234, o_word);
    chk_rng("rdc period ns", SCK_PER_NS[0], SCK_PER_NS[0] * 3 / 2, maxper * CLK_NS);
    chk_rng("rdc busy ns", 1, BUSY_MAX_NS, busy_len * CLK_NS);
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // The run is cut short if it overstays its expected length.
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    i_rst_n = 1'b0;
    i_conv_reset = 1'b0;
    i_cs_n = 1'b0;
    i_interface_select = 1'b0;
    i_read_during_conv = 1'b0;
    i_clock_divider_select = 2'h0;
    i_sar_result = 16'h0000;
    go = 1'b0;
    ign = 1'b0;
    repeat (5) @(negedge i_mclk);
    i_rst_n = 1'b1;
    @(negedge i_mclk);
    chk_val("busy after reset", 16'h0, 16'(o_busy));
    chk_val("data after reset", 16'h0, o_data);
    t_select();
    t_parallel();
    t_rac();
    t_rdc();
    stop_test();
  end
endmodule // tb
